//--- asc_pkg.sv
// asc_pkg: shared constants and types for the conversion sequencer control block.
// Assumes 16-bit register accesses at even byte offsets and a 200 MHz core clock.
`default_nettype none

package asc_pkg;

  // data path widths and instruction memory geometry
  localparam int DATA_W     = 16;
  localparam int IMEM_WORDS = 32;
  localparam int IMEM_AW    = 5;

  // register byte offsets
  localparam logic [7:0] OFS_CONVERT = 8'h06;
  localparam logic [7:0] OFS_CTRL    = 8'h0A;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_PERIOD  = 8'h0E;
  localparam logic [7:0] OFS_IMEM_LO = 8'h80;
  localparam logic [7:0] OFS_IMEM_HI = 8'hBE;

  // sequencer_control fields
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_IRQEN_BIT = 1;

  // sequencer_status fields
  localparam int ST_READY_BIT = 0;
  localparam int ST_ROVR_BIT  = 1;
  localparam int ST_POVR_BIT  = 2;
  localparam int ST_IRAM_BIT  = 3;
  localparam int ST_W         = 4;

  // instruction word fields
  localparam int INSTR_EN_BIT   = 3;
  localparam int INSTR_GAIN_LSB = 1;
  localparam int GAIN_W         = 2;

  // reset values
  localparam logic [DATA_W-1:0] PERIOD_RST = 16'h0000;
  localparam logic [ST_W-1:0]   STATUS_RST = 4'h0;

  // timing: 100 us period tick from the core clock
  localparam int CLK_FREQ_MHZ   = 200;
  localparam int TICK_PERIOD_US = 100;
  localparam int TICK_CYCLES    = TICK_PERIOD_US * CLK_FREQ_MHZ;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_EXAM,
    ST_CONV,
    ST_WAIT
  } asc_state_t;

endpackage

`default_nettype wire

//--- asc_imem_if.sv
// asc_imem_if: write and read port bundle of the instruction memory.
// Assumes the controller owns both ports and the memory answers one cycle later.
`timescale 1ns/1ps
`default_nettype none

interface asc_imem_if #(
  parameter int AW = 5,
  parameter int DW = 16
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  logic          any_enabled;

  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata, input any_enabled);
  modport mem  (input we, input waddr, input wdata, input raddr,
                output rdata, output any_enabled);
endinterface

`default_nettype wire

//--- asc_imem.sv
// asc_imem: 32 x 16 instruction memory with registered read data.
// Assumes writes come from the register port; also tracks which words are enabled.
`timescale 1ns/1ps
`default_nettype none

module asc_imem
  import asc_pkg::*;
#(
  parameter int WORDS = IMEM_WORDS
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // memory port
  asc_imem_if.mem   bus
);

  logic [DATA_W-1:0] mem_r [WORDS];
  logic [DATA_W-1:0] rdata_r;
  logic [WORDS-1:0]  en_r;
  logic [WORDS-1:0]  en_nxt;

  // enable shadow so a start can judge the program without scanning the array
  always_comb
  begin
    en_nxt = en_r;
    if (bus.we)
    begin
      en_nxt[bus.waddr] = bus.wdata[INSTR_EN_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      en_r <= '0;
    end
    else
    begin
      en_r <= en_nxt;
    end
  end

  // storage has no reset; the shadow above says whether anything is valid
  always_ff @(posedge core_clk)
  begin
    if (bus.we)
    begin
      mem_r[bus.waddr] <= bus.wdata;
    end
    // a word never written with its enable set reads as an empty instruction, so
    // random power-up contents cannot start conversions on unprogrammed channels
    rdata_r <= en_r[bus.raddr] ? mem_r[bus.raddr] : '0;
  end

  assign bus.rdata       = rdata_r;
  assign bus.any_enabled = |en_r;

endmodule

`default_nettype wire

//--- asc_seq_ctrl.sv
// asc_seq_ctrl: control, status and period timing of the conversion sequencer.
// Assumes a simple 16-bit register port, synchronous inputs and an external ADC core
// that answers each conversion request with a one-cycle done pulse.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - run bit starts now; clear halts after pass
// - irq raised when enabled and any flag set
// - start with no enabled instruction sets fault
// - timer expiry mid-pass sets period overrun
// - timed pass end with ready uncleared sets overrun
// - pass end sets results ready; software clears
// - any error flag halts after last instruction
// - period register sixteen bits, 100 us units
// - timer reaching period starts a fresh pass
// - period zero restarts immediately after pass
// - pending bit needs enable and error flag
// - manual convert writes ignored while running
// - thirty-two instruction words, one per channel
module asc_seq_ctrl
  import asc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  // adc core
  input  wire logic              conv_done,
  output logic                   conv_req,
  output logic [IMEM_AW-1:0]     conv_chan,
  output logic [GAIN_W-1:0]      conv_gain,
  output logic                   manual_conv,
  // host interrupt, pending and activity flags
  output logic                   pci_irq,
  output logic                   sequencer_pending,
  output logic                   seq_active
);

  localparam int TW = $clog2(TICK_CYC);
  localparam logic [IMEM_AW-1:0] LAST_CH = IMEM_AW'(IMEM_WORDS - 1);

  asc_imem_if #(.AW(IMEM_AW), .DW(DATA_W)) imem_bus ();

  asc_imem #(.WORDS(IMEM_WORDS)) u_imem (
    .core_clk (core_clk),
    .rst      (rst),
    .bus      (imem_bus.mem)
  );

  asc_state_t        state_r, state_nxt;
  logic              run_r, run_nxt;
  logic              irqen_r, irqen_nxt;
  logic [ST_W-1:0]   status_r, status_nxt;
  logic [DATA_W-1:0] period_r, period_nxt;
  logic [IMEM_AW-1:0] ch_r, ch_nxt;
  logic [TW-1:0]     tick_cnt_r, tick_cnt_nxt;
  logic [DATA_W-1:0] per_cnt_r, per_cnt_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic              conv_req_r, conv_req_nxt;
  logic [IMEM_AW-1:0] conv_chan_r, conv_chan_nxt;
  logic [GAIN_W-1:0] conv_gain_r, conv_gain_nxt;
  logic              manual_r, manual_nxt;
  logic              irq_r, irq_nxt;
  logic              pend_r, pend_nxt;
  logic              active_r, active_nxt;

  logic [ST_W-1:0]   status_view;
  logic [ST_W-1:0]   set_v;
  logic [ST_W-1:0]   clr_v;
  logic              wr_ctrl, wr_status, wr_period, wr_conv, wr_imem;
  logic              tick, expire, in_pass, pass_end, err_view, err_stop, period_zero;

  // register port decode
  assign wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_status = reg_wr && (reg_addr == OFS_STATUS);
  assign wr_period = reg_wr && (reg_addr == OFS_PERIOD);
  assign wr_conv   = reg_wr && (reg_addr == OFS_CONVERT);
  assign wr_imem   = reg_wr && (reg_addr >= OFS_IMEM_LO) && (reg_addr <= OFS_IMEM_HI)
                     && !reg_addr[0];

  // instruction memory: host writes, sequencer reads the current channel
  assign imem_bus.we    = wr_imem;
  assign imem_bus.waddr = reg_addr[IMEM_AW:1];
  assign imem_bus.wdata = reg_wdata;
  assign imem_bus.raddr = ch_r;

  // overrun flags are hidden in continuous mode, both on read and for the interrupt
  assign period_zero = (period_r == 16'h0000);
  assign status_view = {status_r[ST_IRAM_BIT],
                        status_r[ST_POVR_BIT] & !period_zero,
                        status_r[ST_ROVR_BIT] & !period_zero,
                        status_r[ST_READY_BIT]};
  assign err_view    = |status_view[ST_IRAM_BIT:ST_ROVR_BIT];

  // 100 us tick and period count; the count restarts with each pass
  assign tick    = (tick_cnt_r == TW'(TICK_CYC - 1));
  assign expire  = tick && !period_zero && ((per_cnt_r + 16'h0001) == period_r);
  assign in_pass = (state_r == ST_READ) || (state_r == ST_EXAM) || (state_r == ST_CONV);

  // sequencer walk, flag events and timers
  always_comb
  begin
    state_nxt     = state_r;
    ch_nxt        = ch_r;
    set_v         = '0;
    pass_end      = 1'b0;
    err_stop      = 1'b0;
    conv_req_nxt  = 1'b0;
    conv_chan_nxt = conv_chan_r;
    conv_gain_nxt = conv_gain_r;
    tick_cnt_nxt  = tick ? '0 : tick_cnt_r + TW'(1);
    per_cnt_nxt   = per_cnt_r;
    if (tick)
    begin
      per_cnt_nxt = expire ? 16'h0000 : per_cnt_r + 16'h0001;
    end
    if (expire && in_pass)
    begin
      set_v[ST_POVR_BIT] = 1'b1;
    end
    case (state_r)
      ST_IDLE:
      begin
        if (run_r && !err_view)
        begin
          if (imem_bus.any_enabled)
          begin
            state_nxt = ST_READ;
          end
          else
          begin
            set_v[ST_IRAM_BIT] = 1'b1;
          end
        end
      end
      ST_READ:
      begin
        state_nxt = ST_EXAM;
      end
      ST_EXAM:
      begin
        if (imem_bus.rdata[INSTR_EN_BIT])
        begin
          conv_req_nxt  = 1'b1;
          conv_chan_nxt = ch_r;
          conv_gain_nxt = imem_bus.rdata[INSTR_GAIN_LSB +: GAIN_W];
          state_nxt     = ST_CONV;
        end
        else if (ch_r == LAST_CH)
        begin
          pass_end = 1'b1;
        end
        else
        begin
          ch_nxt    = ch_r + IMEM_AW'(1);
          state_nxt = ST_READ;
        end
      end
      ST_CONV:
      begin
        if (conv_done)
        begin
          if (ch_r == LAST_CH)
          begin
            pass_end = 1'b1;
          end
          else
          begin
            ch_nxt    = ch_r + IMEM_AW'(1);
            state_nxt = ST_READ;
          end
        end
      end
      ST_WAIT:
      begin
        if (!run_r || err_view)
        begin
          state_nxt = ST_IDLE;
        end
        else if (expire)
        begin
          state_nxt = ST_READ;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    // end of the last instruction: post results and decide what follows
    if (pass_end)
    begin
      set_v[ST_READY_BIT] = 1'b1;
      if (status_r[ST_READY_BIT] && !period_zero)
      begin
        set_v[ST_ROVR_BIT] = 1'b1;
      end
      err_stop = err_view || set_v[ST_ROVR_BIT] || set_v[ST_POVR_BIT];
      if (!run_r || err_stop)
      begin
        state_nxt = ST_IDLE;
      end
      else if (period_zero)
      begin
        state_nxt = ST_READ;
      end
      else
      begin
        state_nxt = ST_WAIT;
      end
    end
    // every new pass begins at channel zero with a fresh period count
    if ((state_nxt == ST_READ) && ((state_r == ST_IDLE) || (state_r == ST_WAIT) || pass_end))
    begin
      ch_nxt       = '0;
      tick_cnt_nxt = '0;
      per_cnt_nxt  = 16'h0000;
    end
  end

  // register file and output staging
  always_comb
  begin
    clr_v      = wr_status ? reg_wdata[ST_W-1:0] : '0;
    status_nxt = (status_r & ~clr_v) | set_v;
    run_nxt    = wr_ctrl ? reg_wdata[CTRL_RUN_BIT] : run_r;
    irqen_nxt  = wr_ctrl ? reg_wdata[CTRL_IRQEN_BIT] : irqen_r;
    period_nxt = wr_period ? reg_wdata : period_r;
    manual_nxt = wr_conv && !run_r;
    irq_nxt    = irqen_r && (|status_view);
    pend_nxt   = irqen_r && err_view;
    active_nxt = (state_nxt != ST_IDLE);
    rdata_nxt  = rdata_r;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_CTRL:   rdata_nxt = {14'h0000, irqen_r, run_r};
        OFS_STATUS: rdata_nxt = {12'h000, status_view};
        OFS_PERIOD: rdata_nxt = period_r;
        default:    rdata_nxt = 16'h0000;
      endcase
    end
  end

  // all state registers; overrun and period counts clear on reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r     <= ST_IDLE;
      run_r       <= 1'b0;
      irqen_r     <= 1'b0;
      status_r    <= STATUS_RST;
      period_r    <= PERIOD_RST;
      ch_r        <= '0;
      tick_cnt_r  <= '0;
      per_cnt_r   <= 16'h0000;
      rdata_r     <= 16'h0000;
      conv_req_r  <= 1'b0;
      conv_chan_r <= '0;
      conv_gain_r <= '0;
      manual_r    <= 1'b0;
      irq_r       <= 1'b0;
      pend_r      <= 1'b0;
      active_r    <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      run_r       <= run_nxt;
      irqen_r     <= irqen_nxt;
      status_r    <= status_nxt;
      period_r    <= period_nxt;
      ch_r        <= ch_nxt;
      tick_cnt_r  <= tick_cnt_nxt;
      per_cnt_r   <= per_cnt_nxt;
      rdata_r     <= rdata_nxt;
      conv_req_r  <= conv_req_nxt;
      conv_chan_r <= conv_chan_nxt;
      conv_gain_r <= conv_gain_nxt;
      manual_r    <= manual_nxt;
      irq_r       <= irq_nxt;
      pend_r      <= pend_nxt;
      active_r    <= active_nxt;
    end
  end

  assign reg_rdata         = rdata_r;
  assign conv_req          = conv_req_r;
  assign conv_chan         = conv_chan_r;
  assign conv_gain         = conv_gain_r;
  assign manual_conv       = manual_r;
  assign pci_irq           = irq_r;
  assign sequencer_pending = pend_r;
  assign seq_active        = active_r;

  // checks on the sequencer behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_run_start;
    (state_r == ST_IDLE) && run_r && !err_view && imem_bus.any_enabled
      |=> (state_r == ST_READ) && (ch_r == '0) ##1 (state_r == ST_EXAM);
  endproperty
  a_run_start: assert property (p_run_start) else $error("run did not start a pass");

  property p_stop_after_pass;
    pass_end && !run_r |=> (state_r == ST_IDLE) && !conv_req_r;
  endproperty
  a_stop_after_pass: assert property (p_stop_after_pass) else $error("no halt on stop");

  property p_irq_gate;
    !irqen_r |=> !pci_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");

  property p_iram_fault;
    (state_r == ST_IDLE) && run_r && !err_view && !imem_bus.any_enabled
      |=> status_r[ST_IRAM_BIT] && (state_r == ST_IDLE);
  endproperty
  a_iram_fault: assert property (p_iram_fault) else $error("iram fault missed");

  property p_zero_period_read;
    reg_rd && (reg_addr == OFS_STATUS) && period_zero |=> (reg_rdata[2:1] == 2'h0);
  endproperty
  a_zero_period_read: assert property (p_zero_period_read) else $error("overrun seen");

  property p_ready_set;
    pass_end |=> status_r[ST_READY_BIT];
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("results ready not set");

  property p_err_halt;
    pass_end && err_stop |=> (state_r == ST_IDLE) [*2];
  endproperty
  a_err_halt: assert property (p_err_halt) else $error("no halt on error");

  property p_continuous;
    pass_end && run_r && !err_stop && period_zero |=> (state_r == ST_READ) && (ch_r == '0);
  endproperty
  a_continuous: assert property (p_continuous) else $error("no back-to-back pass");

  property p_manual_block;
    wr_conv && run_r |=> !manual_conv;
  endproperty
  a_manual_block: assert property (p_manual_block) else $error("manual start leaked");

  property p_set_wins;
    pass_end && wr_status && reg_wdata[ST_READY_BIT] |=> status_r[ST_READY_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a set");

  property p_pending;
    sequencer_pending |-> $past(irqen_r) && $past(err_view);
  endproperty
  a_pending: assert property (p_pending) else $error("pending without cause");

endmodule

`default_nettype wire

//--- asc_adc_model.sv
// asc_adc_model: converter core stand-in that answers each request with a done pulse.
// Assumes one request at a time from the sequencer, all on core_clk.
`timescale 1ns/1ps
`default_nettype none

module asc_adc_model
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // request side
  input  wire logic       conv_req,
  input  wire logic [4:0] conv_chan,
  input  wire logic [1:0] conv_gain,
  input  wire logic [7:0] delay,
  // answer side
  output logic            conv_done
);
  int         req_cnt;
  int         left;
  logic       busy;
  logic [4:0] last_chan;
  logic [1:0] last_gain;

  // delay sets how slow the core is; a slow core stretches the pass past the period
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      req_cnt   <= 0;
      left      <= 0;
      busy      <= 1'b0;
      last_chan <= 5'h00;
      last_gain <= 2'h0;
      conv_done <= 1'b0;
    end
    else
    begin
      conv_done <= 1'b0;
      if (conv_req)
      begin
        req_cnt   <= req_cnt + 1;
        last_chan <= conv_chan;
        last_gain <= conv_gain;
        busy      <= 1'b1;
        left      <= delay;
      end
      else if (busy && left > 1)
        left <= left - 1;
      else if (busy)
      begin
        busy      <= 1'b0;
        conv_done <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

//--- tb.sv
// tb: register-level tests of the conversion sequencer control block.
// Assumes the adc model on the far side and a 10-cycle period tick.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import asc_pkg::*;
  logic        core_clk, rst, reg_wr, reg_rd, conv_done, conv_req;
  logic        manual_conv, pci_irq, sequencer_pending, seq_active;
  logic [7:0]  reg_addr, delay;
  logic [15:0] reg_wdata, reg_rdata;
  logic [4:0]  conv_chan;
  logic [1:0]  conv_gain;
  int          errors, num_checks, man_cnt;

  asc_seq_ctrl #(.TICK_CYC(10)) dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv_done(conv_done), .conv_req(conv_req), .conv_chan(conv_chan),
    .conv_gain(conv_gain), .manual_conv(manual_conv), .pci_irq(pci_irq),
    .sequencer_pending(sequencer_pending), .seq_active(seq_active));

  asc_adc_model adc (.core_clk(core_clk), .rst(rst), .conv_req(conv_req),
    .conv_chan(conv_chan), .conv_gain(conv_gain), .delay(delay), .conv_done(conv_done));

  // 200 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // count manual conversion pulses
  always @(posedge core_clk)
    if (manual_conv === 1'b1)
      man_cnt++;

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data is registered one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [15:0] exp, input string n);
    logic [15:0] v;
    rd(a, v);
    chk(n, v, exp);
  endtask

  // poll status until every bit of m is set, bounded
  task automatic wait_st(input logic [15:0] m);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < 400 && (v & m) !== m; i++)
      rd(OFS_STATUS, v);
    chk("status flag wait", v & m, m);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 3000 && seq_active !== 1'b0; i++)
      @(posedge core_clk);
    #1;
    chk("seq_active", 16'(seq_active), 16'h0000);
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog: the tests need well under 10000 cycles
  initial
  begin
    #200000;
    errors++;
    $display("unexpected watchdog: expected end of tests, seen timeout");
    finish_test();
  end

  initial
  begin
    rst       = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    delay     = 8'h02;
    errors    = 0;
    num_checks = 0;
    man_cnt   = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    // reset values, unused bits, period width
    rc(OFS_CTRL, 16'h0000, "control");
    rc(OFS_STATUS, STATUS_RST, "status");
    rc(OFS_PERIOD, PERIOD_RST, "period");
    rc(8'h20, 16'h0000, "unmapped");
    wr(OFS_PERIOD, 16'hA5C3);
    rc(OFS_PERIOD, 16'hA5C3, "period");
    wr(OFS_PERIOD, 16'h0000);
    wr(OFS_CTRL, 16'hFFFE);
    rc(OFS_CTRL, 16'h0002, "control");
    $display("test fields done");
    // start with no enabled instruction word
    wr(OFS_CTRL, 16'hFFFF);
    rc(OFS_STATUS, 16'h0008, "status");
    chk("pending", 16'(sequencer_pending), 16'h0001);
    chk("irq", 16'(pci_irq), 16'h0001);
    chk("seq_active", 16'(seq_active), 16'h0000);
    wr(OFS_STATUS, 16'h0000);
    rc(OFS_STATUS, 16'h0008, "status");
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_STATUS, 16'h0008);
    rc(OFS_STATUS, 16'h0000, "status");
    wr(OFS_CONVERT, 16'h0001);
    repeat (2) @(posedge core_clk);
    chk("manual pulses", 16'(man_cnt), 16'h0001);
    $display("test program fault done");
    // continuous mode with the first and last channel enabled
    wr(OFS_IMEM_LO, 16'h000C);
    wr(OFS_IMEM_HI, 16'h000A);
    wr(OFS_CTRL, 16'h0001);
    wr(OFS_CONVERT, 16'h0001);
    wait_st(16'h0001);
    repeat (200) @(posedge core_clk);
    chk("requests", 16'(adc.req_cnt >= 6), 16'h0001);
    rc(OFS_STATUS, 16'h0001, "status");
    chk("manual pulses", 16'(man_cnt), 16'h0001);
    wr(OFS_CTRL, 16'h0000);
    wait_idle();
    chk("last chan", 16'(adc.last_chan), 16'h001F);
    chk("last gain", 16'(adc.last_gain), 16'h0001);
    wr(OFS_STATUS, 16'h0001);
    rc(OFS_STATUS, 16'h0000, "status");
    $display("test continuous done");
    // timed passes, ready left uncleared
    wr(OFS_PERIOD, 16'h000C);
    wr(OFS_CTRL, 16'h0003);
    wait_st(16'h0001);
    chk("irq", 16'(pci_irq), 16'h0001);
    chk("pending", 16'(sequencer_pending), 16'h0000);
    wait_st(16'h0002);
    wait_idle();
    rc(OFS_STATUS, 16'h0003, "status");
    chk("pending", 16'(sequencer_pending), 16'h0001);
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_STATUS, 16'h000F);
    repeat (2) @(posedge core_clk);
    chk("irq", 16'(pci_irq), 16'h0000);
    $display("test result overrun done");
    // slow core: timer expires mid-pass
    delay <= 8'h3C;
    wr(OFS_CTRL, 16'h0001);
    wait_st(16'h0004);
    chk("irq", 16'(pci_irq), 16'h0000);
    wait_idle();
    rc(OFS_STATUS, 16'h0005, "status");
    // stop first so continuous mode cannot restart; the stored overrun must be hidden
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_PERIOD, 16'h0000);
    rc(OFS_STATUS, 16'h0001, "status");
    wr(OFS_PERIOD, 16'h000C);
    wr(OFS_STATUS, 16'h0004);
    rc(OFS_STATUS, 16'h0001, "status");
    $display("test period overrun done");
    finish_test();
  end
endmodule

`default_nettype wire
